//--- dv/modem_model.sv
// Behavioural modem or data set on the far side of the serial lines
module modem_model #(
  parameter int LAG = 2
) (
  // Clock
  input  wire logic       ref_clk_i,
  // Scenario controls
  input  wire logic       follow_i,
  input  wire logic [3:0] status_n_i,
  input  wire logic       line_i,
  input  wire logic       ir_line_i,
  // Request from the device
  input  wire logic       rts_n_i,
  // Lines toward the device
  output logic            cts_n_o,
  output logic            dsr_n_o,
  output logic            ring_n_o,
  output logic            dcd_n_o,
  output logic            ser_rx_o,
  output logic            ir_rx_o
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [LAG-1:0] rts_pipe_q;

  // Slow answer: clear-to-send echoes request after LAG clocks
  always_ff @(posedge ref_clk_i) begin
    rts_pipe_q <= {rts_pipe_q[LAG-2:0], rts_n_i};
  end

  // Clear-to-send echoes the request or follows the scenario; the other status lines follow the scenario
  assign cts_n_o  = follow_i ? rts_pipe_q[LAG-1] : status_n_i[0];
  assign dsr_n_o  = status_n_i[1];
  assign ring_n_o = status_n_i[2];
  assign dcd_n_o  = status_n_i[3];
  // Data lines as the scenario sets them
  assign ser_rx_o = line_i;
  assign ir_rx_o  = ir_line_i;
endmodule // modem_model

//--- dv/uart_modem_control_loopback_test.sv
// Self-checking bench for the modem-control and loopback block
`define CHECK(got, exp) \
  begin \
    check_count++; \
    if ((got) !== (exp)) begin \
      bad_count++; \
      $display("wrong value at %0t: got %0h expected %0h", $time, \
               (got), (exp)); \
    end \
  end

module uart_modem_control_loopback_test
  import modem_ctl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        ref_clk = 1'b0;
  logic        rstn    = 1'b0;
  logic [31:0] addr    = 32'h0000_0000;
  logic [31:0] wdata   = 32'h0000_0000;
  logic        wr      = 1'b0;
  logic        rd      = 1'b0;
  logic        fifo_en = 1'b0;
  logic        above   = 1'b0;
  logic        tx      = 1'b1;
  logic        ir_tx_n = 1'b1;
  logic        follow  = 1'b0;
  logic [15:0] lsr     = 16'hA5C3;
  logic [3:0]  stat_n  = 4'hF;
  logic        rx_pin  = 1'b1;
  logic        ir_pin  = 1'b0;
  logic [31:0] rdata, got;
  logic        core_rx, core_ir_rx, c_cts, c_dsr, c_ring, c_dcd;
  logic        lb_o, ir_o, af_o, ser_rx, ir_rx;
  logic        cts_n, dsr_n, ring_n, dcd_n;
  logic        ser_tx, ir_tx_pin, rts_n, u1_n, u2_n;
  logic [2:0]  b;
  int          bad_count   = 0;
  int          check_count = 0;

  // Bench clock, 100 ns period
  always #50 ref_clk = ~ref_clk;

  uart_modem_control_loopback dut_u (
    .ref_clk_i(ref_clk), .rstn_i(rstn),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_write_i(wr),
    .reg_read_i(rd), .reg_rdata_o(rdata),
    .fifo_enable_i(fifo_en), .rx_above_trigger_i(above),
    .line_status_i(lsr), .core_ser_tx_i(tx), .core_ir_tx_n_i(ir_tx_n),
    .core_ser_rx_o(core_rx), .core_ir_rx_o(core_ir_rx),
    .core_cts_n_o(c_cts), .core_dsr_n_o(c_dsr), .core_ring_n_o(c_ring),
    .core_dcd_n_o(c_dcd), .loopback_select_o(lb_o),
    .infrared_mode_enable_o(ir_o), .auto_flow_enable_o(af_o),
    .ser_rx_i(ser_rx), .ir_rx_i(ir_rx), .cts_n_i(cts_n),
    .dsr_n_i(dsr_n), .ring_indicator_in_n_i(ring_n), .dcd_n_i(dcd_n),
    .ser_tx_o(ser_tx), .ir_tx_n_o(ir_tx_pin), .rts_n_o(rts_n),
    .user_output_one_pin_n_o(u1_n), .user_output_two_pin_n_o(u2_n)
  );

  modem_model #(.LAG(2)) far_u (
    .ref_clk_i(ref_clk), .follow_i(follow), .status_n_i(stat_n),
    .line_i(rx_pin), .ir_line_i(ir_pin), .rts_n_i(rts_n),
    .cts_n_o(cts_n), .dsr_n_o(dsr_n), .ring_n_o(ring_n),
    .dcd_n_o(dcd_n), .ser_rx_o(ser_rx), .ir_rx_o(ir_rx)
  );

  // One-cycle register write
  task automatic reg_wr(input logic [31:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= {16'h0000, d};
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr    <= 1'b0;
  endtask

  // One-cycle register read, data taken in the following cycle
  task automatic reg_rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk);
    rd   <= 1'b0;
    @(negedge ref_clk);
    d = rdata;
  endtask

  // Write then read with no idle cycle between the strobes
  task automatic reg_wr_rd(input logic [31:0] a, input logic [15:0] d,
                           output logic [31:0] q);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= {16'h0000, d};
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr    <= 1'b0;
    rd    <= 1'b1;
    @(posedge ref_clk);
    rd    <= 1'b0;
    @(negedge ref_clk);
    q = rdata;
  endtask

  // Let control and pin registers land
  task automatic settle;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  // Counts and verdict, then end of run
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    stop_test();
  end

  // Main sequence
  initial begin
    repeat (8) @(posedge ref_clk);
    @(negedge ref_clk);
    `CHECK({rts_n, u1_n, u2_n, c_dsr}, 4'hF)
    @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    // Register reset value, reserved bits, read-only and unmapped places
    reg_rd(MODEM_CONTROL_OFS, got);
    `CHECK(got, 32'h0000_0000)
    reg_wr_rd(MODEM_CONTROL_OFS, 16'hFFFF, got);
    `CHECK(got, 32'h0000_007E)
    reg_wr(MODEM_CONTROL_OFS, 16'h0000);
    reg_wr(LINE_STATUS_OFS, 16'hFFFF);
    reg_rd(MODEM_CONTROL_OFS, got);
    `CHECK(got, 32'h0000_0000)
    reg_rd(LINE_STATUS_OFS, got);
    `CHECK(got, 32'h0000_00C3)
    reg_rd(32'h5000_111C, got);
    `CHECK(got, 32'h0000_0000)
    // Normal mode: pins are the inverse of their control bits
    for (int k = 0; k < 8; k++) begin
      b = k[2:0];
      reg_wr(MODEM_CONTROL_OFS, {12'h000, b, 1'b0});
      settle();
      `CHECK(rts_n, ~b[0])
      `CHECK(u1_n, ~b[1])
      `CHECK(u2_n, ~b[2])
    end
    // Pin view with all three controls set in serial mode
    reg_rd(PIN_VIEW_OFS, got);
    `CHECK(got, 32'h0000_01F8)
    // Modem inputs pass through outside loopback; slow partner echo
    @(posedge ref_clk);
    follow <= 1'b1;
    settle();
    settle();
    `CHECK(c_cts, 1'b0)
    @(posedge ref_clk);
    follow <= 1'b0;
    // Auto flow gating over every enable and threshold combination
    for (int j = 0; j < 8; j++) begin
      @(posedge ref_clk);
      fifo_en <= j[1];
      above   <= j[0];
      reg_wr(MODEM_CONTROL_OFS, {10'h000, j[2], 3'b000, 1'b1, 1'b0});
      settle();
      `CHECK(rts_n, j[2] & j[1] & j[0])
      `CHECK(af_o, j[2])
    end
    // Serial loopback with external lines set against the looped values
    for (int k = 0; k < 8; k++) begin
      b = k[2:0];
      @(posedge ref_clk);
      tx     <= b[0];
      rx_pin <= ~b[0];
      stat_n <= {b[2], b[1], 1'b0, b[0]};
      reg_wr(MODEM_CONTROL_OFS, {11'h000, 1'b1, b, 1'b0});
      settle();
      `CHECK(ser_tx, 1'b1)
      `CHECK(core_rx, b[0])
      `CHECK({rts_n, u1_n, u2_n}, 3'b111)
      `CHECK(c_cts, ~b[0])
      `CHECK(c_ring, ~b[1])
      `CHECK(c_dcd, ~b[2])
      `CHECK(c_dsr, 1'b1)
      `CHECK(lb_o, 1'b1)
    end
    // Serial and infrared signalling without loopback
    @(posedge ref_clk);
    tx      <= 1'b0;
    ir_tx_n <= 1'b0;
    reg_wr(MODEM_CONTROL_OFS, 16'h0000);
    settle();
    `CHECK({ser_tx, ir_tx_pin}, 2'b01)
    reg_wr(MODEM_CONTROL_OFS, 16'h0040);
    settle();
    `CHECK({ser_tx, ir_tx_pin, ir_o}, 3'b101)
    // Infrared loopback: pin held low, inverted data looped
    @(posedge ref_clk);
    ir_tx_n <= 1'b1;
    reg_wr(MODEM_CONTROL_OFS, 16'h0050);
    settle();
    `CHECK({ir_tx_pin, core_ir_rx}, 2'b01)
    @(posedge ref_clk);
    tx <= 1'b1;
    settle();
    `CHECK({ir_tx_pin, core_ir_rx}, 2'b00)
    stop_test();
  end
endmodule // uart_modem_control_loopback_test

//--- include/modem_ctl_pkg.sv
// Shared constants, types and helpers for the modem-control block
package modem_ctl_pkg;

  // Register byte addresses
  localparam logic [31:0] MODEM_CONTROL_OFS = 32'h5000_1110;
  localparam logic [31:0] LINE_STATUS_OFS   = 32'h5000_1114;
  localparam logic [31:0] PIN_VIEW_OFS      = 32'h5000_1118;

  // Field positions inside modem_control
  localparam int RTS_CTL_BIT     = 1;
  localparam int OUT1_CTL_BIT    = 2;
  localparam int OUT2_CTL_BIT    = 3;
  localparam int LOOPBACK_BIT    = 4;
  localparam int AUTO_FLOW_BIT   = 5;
  localparam int INFRARED_BIT    = 6;

  // Reset value and writable bits of modem_control
  localparam logic [15:0] MODEM_CONTROL_RST = 16'h0000;
  localparam logic [15:0] MODEM_CONTROL_WMASK = 16'h007E;

  // Readable bits of line_status; upper byte reads zero
  localparam logic [15:0] LINE_STATUS_RMASK = 16'h00FF;

  // Signalling mode of the serial lines
  typedef enum logic [1:0] {
    LINK_SERIAL = 2'b00,
    LINK_IR     = 2'b01,
    LOOP_SERIAL = 2'b10,
    LOOP_IR     = 2'b11
  } link_mode_t;

  // Full-word address match
  function automatic logic addr_hit(input logic [31:0] addr,
                                    input logic [31:0] ofs);
    return addr == ofs;
  endfunction

  // Mode from loopback and infrared selects
  function automatic link_mode_t mode_of(input logic loop_sel,
                                         input logic ir_sel);
    return link_mode_t'({loop_sel, ir_sel});
  endfunction

endpackage

//--- src/modem_pin_mux.sv
// Pin and loopback steering for the serial and modem lines
module modem_pin_mux
  import modem_ctl_pkg::*;
(
  // Mode and control fields
  input  wire logic [1:0] mode_i,
  input  wire logic       rts_ctl_i,
  input  wire logic       out1_ctl_i,
  input  wire logic       out2_ctl_i,
  input  wire logic       rts_block_i,
  // Transmitter side and external inputs
  input  wire logic       core_ser_tx_i,
  input  wire logic       core_ir_tx_n_i,
  input  wire logic       ser_rx_i,
  input  wire logic       ir_rx_i,
  input  wire logic       cts_n_i,
  input  wire logic       dsr_n_i,
  input  wire logic       ring_indicator_in_n_i,
  input  wire logic       dcd_n_i,
  // Next pin and receiver values
  output logic            ser_tx_o,
  output logic            ir_tx_n_o,
  output logic            rts_n_o,
  output logic            usr1_n_o,
  output logic            usr2_n_o,
  output logic            ser_rx_o,
  output logic            ir_rx_o,
  output logic            cts_n_o,
  output logic            dsr_n_o,
  output logic            ring_n_o,
  output logic            dcd_n_o
);

  link_mode_t mode;

  assign mode = link_mode_t'(mode_i);

  // Steer pins and receiver inputs by mode
  always_comb begin
    ser_tx_o  = 1'b1;
    ir_tx_n_o = 1'b1;
    rts_n_o   = ~rts_ctl_i | rts_block_i;  // R9 R10
    usr1_n_o  = ~out1_ctl_i;               // R7
    usr2_n_o  = ~out2_ctl_i;               // R5
    ser_rx_o  = ser_rx_i;
    ir_rx_o   = ir_rx_i;
    cts_n_o   = cts_n_i;                   // R2
    dsr_n_o   = dsr_n_i;
    ring_n_o  = ring_indicator_in_n_i;
    dcd_n_o   = dcd_n_i;
    case (mode)
      LINK_SERIAL: begin
        ser_tx_o = core_ser_tx_i;           // R12
      end
      LINK_IR: begin
        ir_tx_n_o = core_ir_tx_n_i;         // R12
      end
      LOOP_SERIAL: begin
        ser_tx_o = 1'b1;                    // R1
        ser_rx_o = core_ser_tx_i;           // R1
      end
      LOOP_IR: begin
        ir_tx_n_o = 1'b0;                   // R4
        ir_rx_o   = ~core_ser_tx_i;         // R4
      end
      default: begin
        ser_tx_o = 1'b1;
      end
    endcase
    // Modem outputs held inactive and fed back in loopback
    if (mode_i[1]) begin
      rts_n_o  = 1'b1;                      // R11
      usr1_n_o = 1'b1;                      // R8
      usr2_n_o = 1'b1;                      // R6
      cts_n_o  = ~rts_ctl_i;                // R3 R11
      dsr_n_o  = 1'b1;                      // R3
      ring_n_o = ~out1_ctl_i;               // R3 R8
      dcd_n_o  = ~out2_ctl_i;               // R3 R6
    end
  end

endmodule // modem_pin_mux

//--- src/rst_sync.sv
// Two-stage release synchroniser for the active-low reset
module rst_sync
  import modem_ctl_pkg::*;
(
  // Clock and raw reset
  input  wire logic ref_clk_i,
  input  wire logic rstn_i,
  // Synchronised reset
  output logic      rstn_o
);

  typedef struct packed {
    logic stage1;
    logic stage2;
  } sync_t;

  sync_t s_q;
  sync_t s_d;

  // Shift a one in after release
  always_comb begin
    s_d        = s_q;
    s_d.stage1 = 1'b1;
    s_d.stage2 = s_q.stage1;
  end

  // Assert at once, release after two edges
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rstn_o = s_q.stage2;

endmodule // rst_sync

//--- src/uart_modem_control_loopback.sv
// Modem control register, pin drive and diagnostic loopback
//
// Function
// R1: serial loopback idles transmit high, loops data
// R2: interrupts behave normally during loopback
// R3: serial loopback replaces modem inputs with outputs
// R4: infrared loopback holds pin low, loops inverted
// R5: second user pin is inverse of control
// R6: loopback holds second user pin high, loops
// R7: first user pin is inverse of control
// R8: loopback holds first user pin high, loops
// R9: request pin low while its bit set
// R10: auto flow forces request high above trigger
// R11: loopback holds request pin high, loops bit
// R12: infrared bit picks serial or pulse signalling
// R13: auto flow needs bit and enabled FIFOs
// R14: reset clears fields, reserved bits read zero
module uart_modem_control_loopback
  import modem_ctl_pkg::*;
#(
  parameter int ADDR_W = 32,
  parameter int DATA_W = 32
) (
  // Clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              rstn_i,
  // Register port
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [DATA_W-1:0] reg_wdata_i,
  input  wire logic              reg_write_i,
  input  wire logic              reg_read_i,
  output logic      [DATA_W-1:0] reg_rdata_o,
  // Neighbouring UART logic
  input  wire logic              fifo_enable_i,
  input  wire logic              rx_above_trigger_i,
  input  wire logic [15:0]       line_status_i,
  input  wire logic              core_ser_tx_i,
  input  wire logic              core_ir_tx_n_i,
  output logic                   core_ser_rx_o,
  output logic                   core_ir_rx_o,
  output logic                   core_cts_n_o,
  output logic                   core_dsr_n_o,
  output logic                   core_ring_n_o,
  output logic                   core_dcd_n_o,
  output logic                   loopback_select_o,
  output logic                   infrared_mode_enable_o,
  output logic                   auto_flow_enable_o,
  // Serial and modem pins
  input  wire logic              ser_rx_i,
  input  wire logic              ir_rx_i,
  input  wire logic              cts_n_i,
  input  wire logic              dsr_n_i,
  input  wire logic              ring_indicator_in_n_i,
  input  wire logic              dcd_n_i,
  output logic                   ser_tx_o,
  output logic                   ir_tx_n_o,
  output logic                   rts_n_o,
  output logic                   user_output_one_pin_n_o,
  output logic                   user_output_two_pin_n_o
);

  typedef struct packed {
    logic [15:0]       ctl;
    logic [DATA_W-1:0] rdata;
    logic              ser_tx;
    logic              ir_tx_n;
    logic              rts_n;
    logic              usr1_n;
    logic              usr2_n;
    logic              ser_rx;
    logic              ir_rx;
    logic              cts_n;
    logic              dsr_n;
    logic              ring_n;
    logic              dcd_n;
  } state_t;

  state_t s_q;
  state_t s_d;

  logic        rst_n;
  logic [31:0] addr32;
  logic        flow_active;
  logic        rts_block;
  logic        nx_ser_tx;
  logic        nx_ir_tx_n;
  logic        nx_rts_n;
  logic        nx_usr1_n;
  logic        nx_usr2_n;
  logic        nx_ser_rx;
  logic        nx_ir_rx;
  logic        nx_cts_n;
  logic        nx_dsr_n;
  logic        nx_ring_n;
  logic        nx_dcd_n;
  logic [15:0] pin_view;

  // Reset release through two flops
  rst_sync u_rst_sync (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .rstn_o    (rst_n)
  );

  // Address widened or cut to the 32-bit map
  if (ADDR_W >= 32) begin : g_addr_cut
    assign addr32 = reg_addr_i[31:0];
  end else begin : g_addr_pad
    assign addr32 = {{(32 - ADDR_W){1'b0}}, reg_addr_i};
  end

  // Hardware flow control gating of the request pin
  assign flow_active = s_q.ctl[AUTO_FLOW_BIT] & fifo_enable_i;   // R13
  assign rts_block   = flow_active & rx_above_trigger_i;         // R10

  // Pin and loopback steering
  modem_pin_mux u_pin_mux (
    .mode_i                (mode_of(s_q.ctl[LOOPBACK_BIT],
                                    s_q.ctl[INFRARED_BIT])),
    .rts_ctl_i             (s_q.ctl[RTS_CTL_BIT]),
    .out1_ctl_i            (s_q.ctl[OUT1_CTL_BIT]),
    .out2_ctl_i            (s_q.ctl[OUT2_CTL_BIT]),
    .rts_block_i           (rts_block),
    .core_ser_tx_i         (core_ser_tx_i),
    .core_ir_tx_n_i        (core_ir_tx_n_i),
    .ser_rx_i              (ser_rx_i),
    .ir_rx_i               (ir_rx_i),
    .cts_n_i               (cts_n_i),
    .dsr_n_i               (dsr_n_i),
    .ring_indicator_in_n_i (ring_indicator_in_n_i),
    .dcd_n_i               (dcd_n_i),
    .ser_tx_o              (nx_ser_tx),
    .ir_tx_n_o             (nx_ir_tx_n),
    .rts_n_o               (nx_rts_n),
    .usr1_n_o              (nx_usr1_n),
    .usr2_n_o              (nx_usr2_n),
    .ser_rx_o              (nx_ser_rx),
    .ir_rx_o               (nx_ir_rx),
    .cts_n_o               (nx_cts_n),
    .dsr_n_o               (nx_dsr_n),
    .ring_n_o              (nx_ring_n),
    .dcd_n_o               (nx_dcd_n)
  );

  // Live pin and modem-status snapshot for software
  assign pin_view = {6'h00, flow_active, s_q.dcd_n, s_q.ring_n, s_q.dsr_n,
                     s_q.cts_n, s_q.ir_tx_n, s_q.ser_tx, s_q.usr2_n,
                     s_q.usr1_n, s_q.rts_n};

  // Next state: register writes, read data, pins
  always_comb begin
    s_d       = s_q;
    s_d.rdata = '0;
    if (reg_write_i && addr_hit(addr32, MODEM_CONTROL_OFS)) begin
      s_d.ctl = reg_wdata_i[15:0] & MODEM_CONTROL_WMASK;         // R14
    end
    if (reg_read_i) begin
      if (addr_hit(addr32, MODEM_CONTROL_OFS)) begin
        s_d.rdata[15:0] = s_q.ctl & MODEM_CONTROL_WMASK;         // R14
      end else if (addr_hit(addr32, LINE_STATUS_OFS)) begin
        s_d.rdata[15:0] = line_status_i & LINE_STATUS_RMASK;
      end else if (addr_hit(addr32, PIN_VIEW_OFS)) begin
        s_d.rdata[15:0] = pin_view;
      end else begin
        s_d.rdata = '0;
      end
    end
    s_d.ser_tx  = nx_ser_tx;
    s_d.ir_tx_n = nx_ir_tx_n;
    s_d.rts_n   = nx_rts_n;
    s_d.usr1_n  = nx_usr1_n;
    s_d.usr2_n  = nx_usr2_n;
    s_d.ser_rx  = nx_ser_rx;
    s_d.ir_rx   = nx_ir_rx;
    s_d.cts_n   = nx_cts_n;
    s_d.dsr_n   = nx_dsr_n;
    s_d.ring_n  = nx_ring_n;
    s_d.dcd_n   = nx_dcd_n;
  end

  // State register; pins idle inactive at reset
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s_q         <= '0;
      s_q.ctl     <= MODEM_CONTROL_RST;                          // R14
      s_q.ser_tx  <= 1'b1;
      s_q.ir_tx_n <= 1'b1;
      s_q.rts_n   <= 1'b1;
      s_q.usr1_n  <= 1'b1;
      s_q.usr2_n  <= 1'b1;
      s_q.ser_rx  <= 1'b1;
      s_q.ir_rx   <= 1'b0;
      s_q.cts_n   <= 1'b1;
      s_q.dsr_n   <= 1'b1;
      s_q.ring_n  <= 1'b1;
      s_q.dcd_n   <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign reg_rdata_o             = s_q.rdata;
  assign ser_tx_o                = s_q.ser_tx;
  assign ir_tx_n_o               = s_q.ir_tx_n;
  assign rts_n_o                 = s_q.rts_n;
  assign user_output_one_pin_n_o = s_q.usr1_n;
  assign user_output_two_pin_n_o = s_q.usr2_n;
  assign core_ser_rx_o           = s_q.ser_rx;
  assign core_ir_rx_o            = s_q.ir_rx;
  assign core_cts_n_o            = s_q.cts_n;                    // R2
  assign core_dsr_n_o            = s_q.dsr_n;
  assign core_ring_n_o           = s_q.ring_n;
  assign core_dcd_n_o            = s_q.dcd_n;
  assign loopback_select_o       = s_q.ctl[LOOPBACK_BIT];
  assign infrared_mode_enable_o  = s_q.ctl[INFRARED_BIT];        // R12
  assign auto_flow_enable_o      = s_q.ctl[AUTO_FLOW_BIT];

  // Helper views of the control fields
  logic lb_q;
  logic ir_q;
  assign lb_q = s_q.ctl[LOOPBACK_BIT];
  assign ir_q = s_q.ctl[INFRARED_BIT];

  // Named steps used by the checks
  sequence loop_serial_s;
    lb_q && !ir_q;
  endsequence

  sequence loop_ir_s;
    lb_q && ir_q;
  endsequence

  sequence normal_s;
    !lb_q;
  endsequence

  sequence ctl_write_s;
    reg_write_i && addr_hit(addr32, MODEM_CONTROL_OFS);
  endsequence

  // Serial loopback: line high, data returned
  chk_serial_loop_path: assert property (  // R1
    @(posedge ref_clk_i) disable iff (!rst_n)
    loop_serial_s |=> ser_tx_o && (core_ser_rx_o == $past(core_ser_tx_i)))
    else $error("serial loopback path wrong");

  // Infrared loopback: pin low, inverted data returned
  chk_ir_loop_path: assert property (  // R4
    @(posedge ref_clk_i) disable iff (!rst_n)
    loop_ir_s |=> !ir_tx_n_o && (core_ir_rx_o == !$past(core_ser_tx_i)))
    else $error("infrared loopback path wrong");

  // Modem inputs follow own outputs in loopback
  chk_status_loop_map: assert property (  // R3
    @(posedge ref_clk_i) disable iff (!rst_n)
    lb_q |=> core_cts_n_o == !$past(s_q.ctl[RTS_CTL_BIT])
         && core_ring_n_o == !$past(s_q.ctl[OUT1_CTL_BIT])
         && core_dcd_n_o == !$past(s_q.ctl[OUT2_CTL_BIT])
         && core_dsr_n_o)
    else $error("loopback status mapping wrong");

  // Normal mode passes modem inputs unchanged
  chk_status_pass_thru: assert property (  // R2
    @(posedge ref_clk_i) disable iff (!rst_n)
    normal_s |=> core_cts_n_o == $past(cts_n_i)
             && core_dsr_n_o == $past(dsr_n_i)
             && core_dcd_n_o == $past(dcd_n_i)
             && core_ring_n_o == $past(ring_indicator_in_n_i))
    else $error("modem status not passed through");

  // Second user pin inverse of its bit
  chk_out2_pin_drive: assert property (  // R5 R6
    @(posedge ref_clk_i) disable iff (!rst_n)
    1'b1 |=> user_output_two_pin_n_o ==
             ($past(lb_q) || !$past(s_q.ctl[OUT2_CTL_BIT])))
    else $error("second user pin level wrong");

  // First user pin inverse of its bit
  chk_out1_pin_drive: assert property (  // R7 R8
    @(posedge ref_clk_i) disable iff (!rst_n)
    1'b1 |=> user_output_one_pin_n_o ==
             ($past(lb_q) || !$past(s_q.ctl[OUT1_CTL_BIT])))
    else $error("first user pin level wrong");

  // Request pin with flow control off
  chk_rts_plain_drive: assert property (  // R9
    @(posedge ref_clk_i) disable iff (!rst_n)
    normal_s ##0 !s_q.ctl[AUTO_FLOW_BIT]
      |=> rts_n_o == !$past(s_q.ctl[RTS_CTL_BIT]))
    else $error("request pin level wrong");

  // Request pin forced high above trigger
  chk_rts_flow_gate: assert property (  // R10 R13
    @(posedge ref_clk_i) disable iff (!rst_n)
    s_q.ctl[AUTO_FLOW_BIT] && fifo_enable_i && rx_above_trigger_i
      |=> rts_n_o)
    else $error("flow control did not block request");

  // Flow control ignored with FIFOs off
  chk_rts_fifo_off: assert property (  // R13
    @(posedge ref_clk_i) disable iff (!rst_n)
    normal_s ##0 !fifo_enable_i ##0 s_q.ctl[RTS_CTL_BIT]
      |=> !rts_n_o)
    else $error("request blocked with FIFOs off");

  // Loopback holds request pin high
  chk_rts_loop_hold: assert property (  // R11
    @(posedge ref_clk_i) disable iff (!rst_n)
    lb_q [*2] |-> rts_n_o)
    else $error("request pin not held in loopback");

  // Infrared select chooses the active pin
  chk_mode_pin_select: assert property (  // R12
    @(posedge ref_clk_i) disable iff (!rst_n)
    normal_s |=> ($past(ir_q)
                  ? (ser_tx_o && ir_tx_n_o == $past(core_ir_tx_n_i))
                  : (ir_tx_n_o && ser_tx_o == $past(core_ser_tx_i))))
    else $error("signalling mode pin select wrong");

  // Written value readable, reserved bits zero
  chk_ctl_write_read: assert property (  // R14
    @(posedge ref_clk_i) disable iff (!rst_n)
    ctl_write_s ##1 (reg_read_i && addr_hit(addr32, MODEM_CONTROL_OFS)
                     && !reg_write_i)
      |=> reg_rdata_o[15:0] == ($past(reg_wdata_i[15:0], 2)
                                & MODEM_CONTROL_WMASK)
          && reg_rdata_o[DATA_W-1:16] == '0)
    else $error("control readback wrong");

  // Read data only in the cycle after a read
  chk_rdata_one_cycle: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    !reg_read_i |=> reg_rdata_o == '0)
    else $error("read data outside its cycle");

  // Upper read data bits always zero
  chk_rdata_upper_zero: assert property (  // R14
    @(posedge ref_clk_i) disable iff (!rst_n)
    reg_read_i |=> reg_rdata_o[DATA_W-1:16] == '0)
    else $error("reserved read data bits set");

  // Receiver takes its pin outside serial loopback
  chk_ser_rx_select: assert property (  // R1
    @(posedge ref_clk_i) disable iff (!rst_n)
    !(lb_q && !ir_q) |=> core_ser_rx_o == $past(ser_rx_i))
    else $error("serial receive source wrong");

endmodule // uart_modem_control_loopback
